// ===== ceb_pkg.sv
// Constants, register map and state types for the completion entry builder
package ceb_pkg;

	// ========================================================================
	// Entry layout
	// ========================================================================
	localparam int unsigned ENTRY_BYTES = 16;
	localparam int unsigned ENTRY_SHIFT = 4;
	localparam logic [63:0] HALF_STEP = 64'h0000_0000_0000_0008;
	localparam int unsigned QID_LSB = 16;
	localparam int unsigned HEAD_LSB = 0;
	localparam int unsigned STATUS_LSB = 17;
	localparam int unsigned PHASE_BIT = 16;
	localparam int unsigned TAG_LSB = 0;
	localparam logic [14:0] STATUS_SUCCESS = 15'h0000;
	localparam logic [31:0] DW_RESERVED = 32'h0000_0000;
	localparam logic PHASE_FIRST_PASS = 1'b1;
	localparam int unsigned PI_BYTES = 8;

	// ========================================================================
	// Register map (byte addresses, one 32-bit word each)
	// ========================================================================
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RING_LAST = 8'h04;
	localparam logic [7:0] REG_BASE_LO = 8'h08;
	localparam logic [7:0] REG_BASE_HI = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_POSTED = 8'h14;

	// Control bit positions
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_MD_SEP = 1;
	localparam int unsigned CTRL_PI_EN = 2;
	localparam int unsigned CTRL_PI_LAST = 3;

	// Status bit positions
	localparam int unsigned STAT_PHASE = 16;
	localparam int unsigned STAT_BUSY = 17;
	localparam int unsigned STAT_LAST_SEG = 18;
	localparam int unsigned STAT_LIST_DONE = 19;

	// Reset values
	localparam logic [15:0] RING_LAST_RST = 16'h000F;
	localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;

	// ========================================================================
	// Types
	// ========================================================================
	typedef enum logic [1:0] {
		CEB_IDLE = 2'b00,
		CEB_LO = 2'b01,
		CEB_HI = 2'b10
	} ceb_fsm_type;

	typedef struct packed {
		ceb_fsm_type fsm;
		logic en;
		logic md_sep;
		logic pi_en;
		logic pi_last;
		logic [15:0] ring_last;
		logic [63:0] base;
		logic [15:0] tail;
		logic phase;
		logic [31:0] posted;
		logic [63:0] mw_addr;
		logic [63:0] mw_data;
		logic [63:0] hi_half;
		logic hv;
		logic [31:0] hdata;
		logic mv;
		logic [31:0] mdata;
		logic blk_seen;
		logic md_seen;
		logic commit;
		logic last_seg;
		logic list_done;
		logic [31:0] prdata;
		logic pslverr;
	} ceb_state_type;

endpackage

// ===== ceb_entry_pack.sv
// Packs the four dwords of one completion entry
`timescale 1ns/1ps
`default_nettype none

module ceb_entry_pack (
	input wire logic [31:0] i_result,          // Command-specific result
	input wire logic i_has_result,             // Command defines a result
	input wire logic [15:0] i_issuing_queue_id, // Issuing queue id
	input wire logic [15:0] i_queue_head_snapshot, // Head pointer sample
	input wire logic [14:0] i_completion_status, // Status field
	input wire logic [15:0] i_command_tag,     // Host-assigned tag
	input wire logic i_phase,                  // Phase value to post
	output logic [127:0] o_entry               // Dword 3..0
);

	logic [31:0] dw0;
	logic [31:0] dw2;
	logic [31:0] dw3;

	// ========================================================================
	// Dword assembly
	// ========================================================================
	always_comb begin
		dw0 = i_has_result ? i_result : ceb_pkg::DW_RESERVED;
		dw2 = ceb_pkg::DW_RESERVED;
		dw2[ceb_pkg::QID_LSB +: 16] = i_issuing_queue_id;
		dw2[ceb_pkg::HEAD_LSB +: 16] = i_queue_head_snapshot;
		dw3 = ceb_pkg::DW_RESERVED;
		dw3[ceb_pkg::STATUS_LSB +: 15] = i_completion_status;
		dw3[ceb_pkg::PHASE_BIT] = i_phase;
		dw3[ceb_pkg::TAG_LSB +: 16] = i_command_tag;
		o_entry = {dw3, dw2, ceb_pkg::DW_RESERVED, dw0};
	end

endmodule

`default_nettype wire

// ===== ceb_top.sv
// Completion entry builder: ring posting, read steering and APB registers
//
// Overview of operation
// - Entries are four dwords, sixteen bytes
// - Dword 0 carries result or reads zero
// - Dword 1 always written as zero
// - Phase bit only in final write
// - Issuing queue id in dword 2 high
// - Head pointer sampled when entry created
// - Status field in dword 3 top bits
// - Phase tag bit 16, inverted per pass
// - First pass after enable posts one
// - Command tag in dword 3 low
// - Metadata inline or separate, never split
// - Block and metadata commit together
// - Protection info first or last eight bytes
// - Bit-bucket data read but not delivered
// - Last-segment descriptor marks final segment
// - Zero status means success
`timescale 1ns/1ps
`default_nettype none

module ceb_top (
	input wire logic i_clk,                    // Core clock
	input wire logic i_rst_n,                  // Async reset, active low
	// APB slave
	input wire logic i_psel,                   // Select
	input wire logic i_penable,                // Access phase
	input wire logic i_pwrite,                 // Write
	input wire logic [7:0] i_paddr,            // Byte address
	input wire logic [31:0] i_pwdata,          // Write data
	output logic o_pready,                     // Always ready
	output logic [31:0] o_prdata,              // Read data
	output logic o_pslverr,                    // Unmapped address
	// Completion request
	input wire logic i_cpl_valid,              // Completion offered
	output logic o_cpl_ready,                  // Completion taken
	input wire logic [31:0] i_cpl_result,      // Command result
	input wire logic i_cpl_has_result,         // Result defined
	input wire logic [15:0] i_issuing_queue_id, // Issuing queue
	input wire logic [15:0] i_queue_head_live, // Live head pointer
	input wire logic [14:0] i_completion_status, // Status field
	input wire logic [15:0] i_command_tag,     // Command tag
	// Memory write master
	output logic o_mw_valid,                   // Write request
	input wire logic i_mw_ready,               // Write accepted
	output logic [63:0] o_mw_addr,             // Byte address
	output logic [63:0] o_mw_data,             // Eight bytes
	output logic o_mw_last,                    // Final write of entry
	// Read data from medium
	input wire logic i_rd_valid,               // Medium data valid
	output logic o_rd_ready,                   // Medium data taken
	input wire logic [31:0] i_rd_data,         // Medium data
	input wire logic i_rd_discard,             // Bit-bucket range
	input wire logic i_rd_is_md,               // Word is metadata
	// Host data stream
	output logic o_host_valid,                 // Data to host
	input wire logic i_host_ready,             // Host accepts
	output logic [31:0] o_host_data,           // Data word
	// Separate metadata stream
	output logic o_mdbuf_valid,                // Metadata to buffer
	input wire logic i_mdbuf_ready,            // Buffer accepts
	output logic [31:0] o_mdbuf_data,          // Metadata word
	// Write commit
	input wire logic i_blk_written,            // Block stored pulse
	input wire logic i_md_written,             // Metadata stored pulse
	output logic o_commit,                     // Commit pulse
	// Protection info placement
	output logic o_pi_enable,                  // Protection active
	output logic o_pi_at_end,                  // Uses last bytes
	output logic [3:0] o_pi_bytes,             // Protection size
	// Segment list
	input wire logic i_cmd_start,              // New command pulse
	input wire logic i_desc_valid,             // Descriptor seen
	input wire logic i_desc_last_seg,          // Descriptor is last-segment
	input wire logic i_seg_fetched,            // Segment fetched pulse
	output logic o_fetch_final,                // Next fetch is final
	output logic o_fetch_allow                 // More segments allowed
);

	ceb_pkg::ceb_state_type s_q;
	ceb_pkg::ceb_state_type s_d;
	logic [127:0] entry;
	logic [63:0] slot_addr;
	logic take_cpl;
	logic to_md;
	logic rd_take;
	logic ok_write;
	logic blk_now;
	logic md_now;

	// ========================================================================
	// Helpers
	// ========================================================================
	// Address decode shared by read and write paths
	function automatic logic ceb_mapped(input logic [7:0] a);
		case (a)
			ceb_pkg::REG_CTRL, ceb_pkg::REG_RING_LAST, ceb_pkg::REG_BASE_LO,
			ceb_pkg::REG_BASE_HI, ceb_pkg::REG_STATUS, ceb_pkg::REG_POSTED: begin
				ceb_mapped = 1'b1;
			end
			default: begin
				ceb_mapped = 1'b0;
			end
		endcase
	endfunction

	// Ring slot byte address
	function automatic logic [63:0] ceb_slot(input logic [63:0] b, input logic [15:0] t);
		ceb_slot = b + {44'h0, t, 4'h0};
	endfunction

	// ========================================================================
	// Entry assembly, sampled at acceptance
	// ========================================================================
	ceb_entry_pack u_pack (
		.i_result(i_cpl_result),
		.i_has_result(i_cpl_has_result),
		.i_issuing_queue_id(i_issuing_queue_id),
		.i_queue_head_snapshot(i_queue_head_live),
		.i_completion_status(i_completion_status),
		.i_command_tag(i_command_tag),
		.i_phase(s_q.phase),
		.o_entry(entry)
	);

	// Handshake terms
	assign slot_addr = ceb_slot(s_q.base, s_q.tail);
	assign take_cpl = i_cpl_valid && s_q.en && (s_q.fsm == ceb_pkg::CEB_IDLE);
	assign to_md = i_rd_is_md && s_q.md_sep;
	assign ok_write = i_psel && i_penable && i_pwrite;
	assign blk_now = s_q.blk_seen || i_blk_written;
	assign md_now = s_q.md_seen || i_md_written;

	// Read steering ready
	always_comb begin
		if (i_rd_discard) begin
			o_rd_ready = 1'b1;
		end else if (to_md) begin
			o_rd_ready = !s_q.mv || i_mdbuf_ready;
		end else begin
			o_rd_ready = !s_q.hv || i_host_ready;
		end
	end
	assign rd_take = i_rd_valid && o_rd_ready;

	// ========================================================================
	// Next state
	// ========================================================================
	always_comb begin
		s_d = s_q;
		s_d.commit = 1'b0;

		// APB read data latched in the setup cycle
		if (i_psel && !i_penable) begin
			s_d.pslverr = !ceb_mapped(i_paddr);
			case (i_paddr)
				ceb_pkg::REG_CTRL: begin
					s_d.prdata = {28'h0, s_q.pi_last, s_q.pi_en, s_q.md_sep, s_q.en};
				end
				ceb_pkg::REG_RING_LAST: begin
					s_d.prdata = {16'h0, s_q.ring_last};
				end
				ceb_pkg::REG_BASE_LO: begin
					s_d.prdata = s_q.base[31:0];
				end
				ceb_pkg::REG_BASE_HI: begin
					s_d.prdata = s_q.base[63:32];
				end
				ceb_pkg::REG_STATUS: begin
					s_d.prdata = {12'h0, s_q.list_done, s_q.last_seg,
						(s_q.fsm != ceb_pkg::CEB_IDLE), s_q.phase, s_q.tail};
				end
				ceb_pkg::REG_POSTED: begin
					s_d.prdata = s_q.posted;
				end
				default: begin
					s_d.prdata = 32'h0000_0000;
				end
			endcase
		end

		// APB writes
		if (ok_write) begin
			case (i_paddr)
				ceb_pkg::REG_CTRL: begin
					s_d.en = i_pwdata[ceb_pkg::CTRL_ENABLE];
					s_d.md_sep = i_pwdata[ceb_pkg::CTRL_MD_SEP];
					s_d.pi_en = i_pwdata[ceb_pkg::CTRL_PI_EN];
					s_d.pi_last = i_pwdata[ceb_pkg::CTRL_PI_LAST];
					if (i_pwdata[ceb_pkg::CTRL_ENABLE] && !s_q.en) begin
						s_d.tail = 16'h0000;
						s_d.phase = ceb_pkg::PHASE_FIRST_PASS;
						s_d.posted = 32'h0000_0000;
					end
				end
				ceb_pkg::REG_RING_LAST: begin
					s_d.ring_last = i_pwdata[15:0];
				end
				ceb_pkg::REG_BASE_LO: begin
					s_d.base[31:0] = {i_pwdata[31:ceb_pkg::ENTRY_SHIFT], 4'h0};
				end
				ceb_pkg::REG_BASE_HI: begin
					s_d.base[63:32] = i_pwdata;
				end
				default: begin
				end
			endcase
		end

		// Ring posting sequence
		case (s_q.fsm)
			ceb_pkg::CEB_IDLE: begin
				if (take_cpl) begin
					s_d.mw_addr = slot_addr;
					s_d.mw_data = entry[63:0];
					s_d.hi_half = entry[127:64];
					s_d.fsm = ceb_pkg::CEB_LO;
				end
			end
			ceb_pkg::CEB_LO: begin
				if (i_mw_ready) begin
					s_d.mw_addr = s_q.mw_addr + ceb_pkg::HALF_STEP;
					s_d.mw_data = s_q.hi_half;
					s_d.fsm = ceb_pkg::CEB_HI;
				end
			end
			ceb_pkg::CEB_HI: begin
				if (i_mw_ready) begin
					s_d.fsm = ceb_pkg::CEB_IDLE;
					s_d.posted = s_q.posted + 32'h0000_0001;
					if (s_q.tail == s_q.ring_last) begin
						s_d.tail = 16'h0000;
						s_d.phase = !s_q.phase;
					end else begin
						s_d.tail = s_q.tail + 16'h0001;
					end
				end
			end
			default: begin
				s_d.fsm = ceb_pkg::CEB_IDLE;
			end
		endcase

		// Output registers drain
		if (s_q.hv && i_host_ready) begin
			s_d.hv = 1'b0;
		end
		if (s_q.mv && i_mdbuf_ready) begin
			s_d.mv = 1'b0;
		end
		if (rd_take && !i_rd_discard) begin
			if (to_md) begin
				s_d.mv = 1'b1;
				s_d.mdata = i_rd_data;
			end else begin
				s_d.hv = 1'b1;
				s_d.hdata = i_rd_data;
			end
		end

		if (blk_now && (md_now || !s_q.md_sep)) begin
			s_d.commit = 1'b1;
			s_d.blk_seen = 1'b0;
			s_d.md_seen = 1'b0;
		end else begin
			s_d.blk_seen = blk_now;
			s_d.md_seen = md_now;
		end

		if (i_cmd_start) begin
			s_d.last_seg = 1'b0;
			s_d.list_done = 1'b0;
		end else if (i_seg_fetched && s_q.last_seg) begin
			s_d.list_done = 1'b1;
		end
		// Descriptor set wins over a same-cycle start
		if (i_desc_valid && i_desc_last_seg) begin
			s_d.last_seg = 1'b1;
		end
	end

	// ========================================================================
	// State register
	// ========================================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{
				fsm: ceb_pkg::CEB_IDLE,
				ring_last: ceb_pkg::RING_LAST_RST,
				base: ceb_pkg::BASE_RST,
				phase: ceb_pkg::PHASE_FIRST_PASS,
				default: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ========================================================================
	// Outputs
	// ========================================================================
	assign o_pready = 1'b1;
	assign o_prdata = s_q.prdata;
	assign o_pslverr = s_q.pslverr;
	assign o_cpl_ready = take_cpl;
	assign o_mw_valid = (s_q.fsm == ceb_pkg::CEB_LO) || (s_q.fsm == ceb_pkg::CEB_HI);
	assign o_mw_addr = s_q.mw_addr;
	assign o_mw_data = s_q.mw_data;
	assign o_mw_last = (s_q.fsm == ceb_pkg::CEB_HI);
	assign o_host_valid = s_q.hv;
	assign o_host_data = s_q.hdata;
	assign o_mdbuf_valid = s_q.mv;
	assign o_mdbuf_data = s_q.mdata;
	assign o_commit = s_q.commit;
	assign o_pi_enable = s_q.pi_en;
	assign o_pi_at_end = s_q.pi_en && s_q.pi_last;
	assign o_pi_bytes = s_q.pi_en ? 4'(ceb_pkg::PI_BYTES) : 4'h0;
	assign o_fetch_final = s_q.last_seg && !s_q.list_done;
	assign o_fetch_allow = !s_q.list_done;

endmodule

`default_nettype wire

// ===== ceb_chk.sv
// Port checker for the completion entry builder
`timescale 1ns/1ps
`default_nettype none

module ceb_chk (
	input wire logic i_clk, // Core clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic i_cpl_valid, // Offer
	input wire logic o_cpl_ready, // Taken
	input wire logic [31:0] i_cpl_result, // Result
	input wire logic i_cpl_has_result, // Result defined
	input wire logic [15:0] i_issuing_queue_id, // Queue
	input wire logic [15:0] i_queue_head_live, // Live head
	input wire logic [14:0] i_completion_status, // Status
	input wire logic [15:0] i_command_tag, // Tag
	input wire logic o_mw_valid, // Write request
	input wire logic i_mw_ready, // Write accepted
	input wire logic [63:0] o_mw_addr, // Address
	input wire logic [63:0] o_mw_data, // Data
	input wire logic o_mw_last, // Final write
	input wire logic i_rd_valid, // Medium word
	input wire logic i_rd_discard, // Discard range
	input wire logic o_rd_ready, // Medium taken
	input wire logic o_host_valid, // Host word
	input wire logic o_mdbuf_valid, // Metadata word
	input wire logic o_commit, // Commit pulse
	input wire logic o_pi_enable, // Protection on
	input wire logic [3:0] o_pi_bytes, // Protection size
	input wire logic o_fetch_final, // Final segment
	input wire logic o_fetch_allow, // Fetch allowed
	input wire logic i_seg_fetched, // Segment fetched
	input wire logic i_cmd_start // New command
);
	logic [94:0] cap_q; // Result, queue, head, status, tag

	// ==========================================================
	// Fields sampled at acceptance
	// ==========================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_q <= '0;
		end else if (i_cpl_valid && o_cpl_ready) begin
			cap_q <= {i_cpl_has_result ? i_cpl_result : 32'h0, i_issuing_queue_id,
				i_queue_head_live, i_completion_status, i_command_tag};
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence acc_s;
		i_cpl_valid && o_cpl_ready;
	endsequence
	sequence lo_done_s;
		o_mw_valid && !o_mw_last && i_mw_ready;
	endsequence

	// ==========================================================
	// Assertions
	// ==========================================================
	hold_write_a: assert property (o_mw_valid && !i_mw_ready |=> o_mw_valid &&
		$stable(o_mw_addr) && $stable(o_mw_data) && $stable(o_mw_last))
		else $error("write request changed while stalled");
	first_write_a: assert property (acc_s |=> o_mw_valid && !o_mw_last &&
		o_mw_addr[3:0] == 4'h0 && o_mw_data == {32'h0, cap_q[94:63]})
		else $error("first write content wrong");
	second_write_a: assert property (lo_done_s |=> o_mw_valid && o_mw_last &&
		o_mw_addr == $past(o_mw_addr) + 64'h8)
		else $error("second write missing or misplaced");
	entry_fields_a: assert property (o_mw_valid && o_mw_last |->
		{o_mw_data[63:49], o_mw_data[47:0]} == {cap_q[30:0], cap_q[62:31]})
		else $error("entry fields wrong");
	busy_refuse_a: assert property (o_mw_valid |-> !o_cpl_ready)
		else $error("completion taken while busy");
	entry_end_a: assert property (o_mw_valid && o_mw_last && i_mw_ready |=> !o_mw_valid)
		else $error("extra write after entry");
	commit_pulse_a: assert property (o_commit |=> !o_commit)
		else $error("commit longer than a pulse");
	pi_size_a: assert property (o_pi_bytes == (o_pi_enable ? 4'h8 : 4'h0))
		else $error("protection size wrong");
	discard_drop_a: assert property (i_rd_valid && i_rd_discard && !o_host_valid &&
		!o_mdbuf_valid |-> o_rd_ready ##1 !o_host_valid && !o_mdbuf_valid)
		else $error("discarded word delivered");
	final_seg_a: assert property (o_fetch_final && i_seg_fetched && !i_cmd_start
		|=> !o_fetch_allow)
		else $error("fetch allowed after final segment");
endmodule

bind ceb_top ceb_chk u_chk (.*);
`default_nettype wire

// ===== ceb_host_mem.sv
// Host memory model holding the completion ring
`timescale 1ns/1ps
`default_nettype none

module ceb_host_mem (
	input wire logic i_clk, // Core clock
	input wire logic i_slow, // Stall every other cycle
	input wire logic i_mw_valid, // Write request
	output logic o_mw_ready, // Write accepted
	input wire logic [63:0] i_mw_addr, // Byte address
	input wire logic [63:0] i_mw_data // Eight bytes
);
	logic [63:0] mem [0:63];
	logic tog_q = 1'b0;

	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 64'h0;
		end
	end
	// Ready pattern and write capture
	always @(posedge i_clk) begin
		tog_q <= !tog_q;
		if (i_mw_valid && o_mw_ready) begin
			mem[i_mw_addr[8:3]] <= i_mw_data;
		end
	end
	assign o_mw_ready = !i_slow || tog_q;
endmodule
`default_nettype wire

// ===== ceb_tb_top.sv
// Self-checking testbench for the completion entry builder
`timescale 1ns/1ps
`default_nettype none

module ceb_tb_top;
	logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, slow, er;
	logic i_cpl_valid, o_cpl_ready, i_cpl_has_result, o_mw_valid, i_mw_ready, o_mw_last;
	logic i_rd_valid, o_rd_ready, i_rd_discard, i_rd_is_md, o_host_valid, i_host_ready;
	logic o_mdbuf_valid, i_mdbuf_ready, i_blk_written, i_md_written, o_commit, seen;
	logic o_pi_enable, o_pi_at_end, i_cmd_start, i_desc_valid, i_desc_last_seg, ph;
	logic i_seg_fetched, o_fetch_final, o_fetch_allow;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, i_cpl_result, i_rd_data, o_host_data, o_mdbuf_data, rd;
	logic [15:0] i_issuing_queue_id, i_queue_head_live, i_command_tag, tail;
	logic [14:0] i_completion_status;
	logic [63:0] o_mw_addr, o_mw_data;
	logic [3:0] o_pi_bytes;
	int n_errors, checks_done, n;

	ceb_top uut (.*);
	ceb_host_mem u_mem (.i_clk(i_clk), .i_slow(slow), .i_mw_valid(o_mw_valid),
		.o_mw_ready(i_mw_ready), .i_mw_addr(o_mw_addr), .i_mw_data(o_mw_data));

	// ==========================================================
	// Checking and closing
	// ==========================================================
	task chk(input logic [63:0] s, input logic [63:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task summarize();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task hang();
		n_errors++;
		summarize();
	endtask

	// APB transfer, result left in rd and er
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 50);
		if (n >= 50) hang();
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task t_regs();
		apb(0, ceb_pkg::REG_RING_LAST, 0);
		chk(rd, {16'h0, ceb_pkg::RING_LAST_RST});
		apb(0, ceb_pkg::REG_STATUS, 0);
		chk(rd, 32'h0001_0000);
		apb(0, 8'h3C, 0);
		chk({er, rd}, {1'b1, 32'h0});
		i_cpl_valid <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk(o_cpl_ready, 0);
		i_cpl_valid <= 1'b0;
		apb(1, ceb_pkg::REG_RING_LAST, 1);
		apb(1, ceb_pkg::REG_BASE_LO, 32'h100);
		apb(1, ceb_pkg::REG_BASE_HI, 0);
		apb(1, ceb_pkg::REG_CTRL, 1);
		apb(1, ceb_pkg::REG_POSTED, 32'h55);
		apb(0, ceb_pkg::REG_POSTED, 0);
		chk({er, rd}, 0);
	endtask

	// One completion through the two-entry ring
	task cpl(input int k);
		logic [14:0] st;
		logic [31:0] res;
		st = (k == 1) ? ceb_pkg::STATUS_SUCCESS : 15'h7FF0 | 15'(k);
		res = 32'hD000_0000 | 32'(k);
		@(posedge i_clk);
		slow <= k[0];
		i_cpl_valid <= 1'b1;
		i_cpl_result <= res;
		i_cpl_has_result <= k[0];
		i_issuing_queue_id <= 16'h0A00 | 16'(k);
		i_queue_head_live <= 16'h0040 | 16'(k);
		i_completion_status <= st;
		i_command_tag <= 16'hC000 | 16'(k);
		n = 0;
		do begin @(posedge i_clk); n++; end while (o_cpl_ready !== 1'b1 && n < 50);
		if (n >= 50) hang();
		i_cpl_valid <= 1'b0;
		i_queue_head_live <= 16'hFFFF;
		n = 0;
		do begin @(posedge i_clk); n++; end
		while (!(o_mw_valid === 1'b1 && o_mw_last === 1'b1 && i_mw_ready === 1'b1) && n < 50);
		if (n >= 50) hang();
		@(posedge i_clk);
		chk(u_mem.mem[32 + 2 * tail], {32'h0, k[0] ? res : 32'h0});
		chk(u_mem.mem[33 + 2 * tail], {st, ph, 16'hC000 | 16'(k), 16'h0A00 | 16'(k),
			16'h0040 | 16'(k)});
		if (tail == 16'h1) begin
			tail = 0;
			ph = !ph;
		end else begin
			tail++;
		end
	endtask

	task t_ring();
		tail = 0;
		ph = 1'b1;
		for (int k = 0; k < 3; k++) begin
			cpl(k);
		end
		apb(0, ceb_pkg::REG_STATUS, 0);
		chk(rd, {15'h0, ph, tail});
		apb(0, ceb_pkg::REG_POSTED, 0);
		chk(rd, 3);
	endtask

	// One medium word and where it lands
	task rdw(input logic [31:0] d, input logic dis, md, eh, em);
		@(posedge i_clk);
		i_rd_valid <= 1'b1;
		i_rd_data <= d;
		i_rd_discard <= dis;
		i_rd_is_md <= md;
		n = 0;
		do begin @(posedge i_clk); n++; end while (o_rd_ready !== 1'b1 && n < 50);
		i_rd_valid <= 1'b0;
		@(posedge i_clk);
		chk({o_host_valid, o_mdbuf_valid}, {eh, em});
		chk(em ? o_mdbuf_data : o_host_data, (eh || em) ? d : 32'h1111_2222);
	endtask

	task t_read();
		rdw(32'h1111_2222, 0, 1, 1, 0);
		apb(1, ceb_pkg::REG_CTRL, 32'hF);
		@(posedge i_clk);
		chk({o_pi_enable, o_pi_at_end, o_pi_bytes}, 6'b11_1000);
		rdw(32'h3333_4444, 0, 1, 0, 1);
		rdw(32'h5555_6666, 1, 0, 0, 0);
		rdw(32'h7777_8888, 0, 0, 1, 0);
	endtask

	task t_commit();
		@(posedge i_clk);
		i_blk_written <= 1'b1;
		@(posedge i_clk);
		i_blk_written <= 1'b0;
		seen = 0;
		repeat (4) @(posedge i_clk) seen |= o_commit;
		chk(seen, 0);
		i_md_written <= 1'b1;
		@(posedge i_clk);
		i_md_written <= 1'b0;
		seen = 0;
		repeat (4) @(posedge i_clk) seen |= o_commit;
		chk(seen, 1);
		apb(1, ceb_pkg::REG_CTRL, 32'h5);
		i_blk_written <= 1'b1;
		@(posedge i_clk);
		i_blk_written <= 1'b0;
		seen = 0;
		repeat (4) @(posedge i_clk) seen |= o_commit;
		chk(seen, 1);
		chk({o_pi_enable, o_pi_at_end, o_pi_bytes}, 6'b10_1000);
	endtask

	task t_seg();
		@(posedge i_clk);
		i_desc_valid <= 1'b1;
		i_desc_last_seg <= 1'b1;
		@(posedge i_clk);
		i_desc_valid <= 1'b0;
		i_desc_last_seg <= 1'b0;
		@(posedge i_clk);
		chk({o_fetch_final, o_fetch_allow}, 2'b11);
		i_seg_fetched <= 1'b1;
		@(posedge i_clk);
		i_seg_fetched <= 1'b0;
		@(posedge i_clk);
		chk(o_fetch_allow, 0);
		i_cmd_start <= 1'b1;
		@(posedge i_clk);
		i_cmd_start <= 1'b0;
		@(posedge i_clk);
		chk({o_fetch_final, o_fetch_allow}, 2'b01);
	endtask

	// ==========================================================
	// Clock and main sequence
	// ==========================================================
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		{i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_cpl_valid} = '0;
		{i_cpl_result, i_cpl_has_result, i_issuing_queue_id, i_queue_head_live} = '0;
		{i_completion_status, i_command_tag, i_rd_valid, i_rd_data, i_rd_discard} = '0;
		{i_rd_is_md, i_blk_written, i_md_written, i_cmd_start, i_desc_valid, slow} = '0;
		{i_desc_last_seg, i_seg_fetched} = '0;
		i_host_ready = 1'b1;
		i_mdbuf_ready = 1'b1;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_regs();
		t_ring();
		t_read();
		t_commit();
		t_seg();
		summarize();
	end
endmodule
`default_nettype wire
